// ### hdl/ssmc_pkg.sv
/*
  constants shared by the sleep mode controller and its idle timer.
  assumes a 100 MHz system clock and a 32-bit avalon-mm register bus.
*/
// Contract
// - codes 11100/1x010/1x001 force deep/light/wake
// - request bits clear themselves after a delay
// - no auto deep sleep when disabled
// - light sleep after idle time in normal
// - deep sleep after long idle in light
// - deep sleep exits on motion or wake
// - idle times come from entry delay register
// - clearing enables in normal keeps normal
// - clearing enables asleep keeps sleeping until wake
// - sleep enable bit, reset value one
// - low five bits select sleep usage
// - auto deep sleep enable, reset value one
package ssmc_pkg;
  // ==========================================
  // register map (word index, byte = 4*index)
  localparam logic [7:0] PSC_IDX   = 8'h05;   // power_state_control
  localparam logic [7:0] DLY_IDX   = 8'h10;   // idle entry delay
  localparam logic [7:0] STAT_IDX  = 8'h11;   // state status
  // ==========================================
  // power_state_control fields
  localparam int         LED_BIT   = 7;
  localparam int         SLP_BIT   = 4;
  localparam int         DEEP_BIT  = 3;
  localparam logic [7:0] PSC_RST   = 8'hB8;   // led, 01, sleep, deep on
  localparam logic [2:0] REQ_MASK  = 3'h7;
  localparam logic [4:0] CODE_DEEP = 5'h1C;   // 11100
  localparam logic [2:0] CODE_LITE = 3'h2;    // 1x010 low part
  localparam logic [2:0] CODE_WAKE = 3'h1;    // 1x001 low part
  // ==========================================
  // idle entry delay fields and reset values
  localparam logic [9:0] LITE_MS_RST = 10'h100; // 256 ms
  localparam logic [7:0] DEEP_S_RST  = 8'h3D;   // 61 s
  localparam int         DEEP_LSB    = 16;
  // ==========================================
  // timing
  localparam int TICK_MS      = 1;            // idle tick, ms
  localparam int CLK_MHZ      = 100;
  localparam int MS_CYC       = TICK_MS * CLK_MHZ * 1000;
  localparam int MS_PER_S     = 1000;
  localparam int REQ_CLR_CYC  = 8;            // request self-clear delay
  // ==========================================
  // power states, one-hot
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_LIGHT  = 3'b010,
    ST_DEEP   = 3'b100
  } ssmc_state_t;
endpackage : ssmc_pkg

// ### hdl/ssmc_timer_if.sv
/*
  carrier between the controller and its idle timer.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface ssmc_timer_if;
  logic        restart;    // clear elapsed idle time
  logic [17:0] target_ms;  // idle time wanted, ms
  logic        expired;    // idle time reached
  modport ctrl  (output restart, output target_ms, input expired);
  modport timer (input restart, input target_ms, output expired);
endinterface : ssmc_timer_if

// ### hdl/ssmc_idle_timer.sv
/*
  no-motion idle timer counting whole milliseconds.
  assumes restart is pulsed by the controller on motion or state change.
*/
`timescale 1ns/10ps
module ssmc_idle_timer
  import ssmc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC   // cycles per ms tick
)(
  input  wire logic  clk,
  input  wire logic  nrst,
  ssmc_timer_if.timer tif
);
  // ==========================================
  // millisecond prescaler
  logic [31:0] pre_q;   // cycles into this ms
  logic [17:0] ms_q;    // elapsed idle ms
  logic        tick;    // one ms elapsed

  assign tick = (pre_q == 32'(MS_CYCLES - 1));

  // prescaler restarts with the count so ticks stay aligned
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pre_q <= 32'h0000_0000;
    else if (tif.restart || tick)
      pre_q <= 32'h0000_0000;
    else
      pre_q <= pre_q + 32'h0000_0001;
  end

  // ==========================================
  // elapsed count, saturates so it never wraps back
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ms_q <= 18'h0_0000;
    else if (tif.restart)
      ms_q <= 18'h0_0000;
    else if (tick && ms_q != 18'h3_FFFF)
      ms_q <= ms_q + 18'h0_0001;
  end

  // a zero target expires at once
  assign tif.expired = (ms_q >= tif.target_ms);
endmodule : ssmc_idle_timer

// ### hdl/ssmc_ctrl.sv
/*
  sensor sleep mode controller: power state machine plus its registers.
  assumes an avalon-mm master on the system clock and a motion pulse
  from the motion engine on the same clock.
*/
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ssmc_ctrl
  import ssmc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC   // cycles per ms, shorten in sim
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave, byte address
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // motion engine, same clock
  input  wire logic        motion_detect,
  // power state outputs
  output logic [2:0]       power_state,
  output logic             led_gating_enable
);
  import ssmc_pkg::*;

  // ==========================================
  // declarations
  ssmc_state_t state_q;      // current power state
  ssmc_state_t state_d;      // next power state
  logic [7:0]  psc_q;        // power_state_control
  logic [9:0]  lite_ms_q;    // light sleep idle time, ms
  logic [7:0]  deep_s_q;     // deep sleep idle time, s
  logic [3:0]  clr_cnt_q;    // request self-clear delay
  logic        ack_q;        // bus answer cycle
  logic [31:0] rdata_q;      // read data register
  logic [7:0]  word_idx;     // word index of access
  logic        wr_take;      // write takes effect now
  logic        psc_wr;       // write to control register
  logic        force_deep;   // forced deep sleep code
  logic        force_lite;   // forced light sleep code
  logic        force_wake;   // forced wakeup code
  logic        sleep_en;     // sleep allowed
  logic        deep_en;      // auto deep sleep allowed
  logic        req_pend;     // some request bit is set
  logic        req_done;     // self-clear delay over

  ssmc_timer_if tif ();      // idle timer carrier

  // ==========================================
  // bus decode
  // registers sit one per 32-bit word
  assign word_idx = avs_address[9:2];

  // one wait cycle per access; the answer edge is ack_q high
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  // write commits only on the edge where waitrequest is low
  assign wr_take = avs_write && ack_q;

  // only the low byte lane carries control bits
  assign psc_wr = wr_take && (word_idx == PSC_IDX)
                  && avs_byteenable[0];

  // answer cycle toggles so back to back requests each wait once
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  // ==========================================
  // read data, captured in the wait cycle
  // unmapped words read as zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      unique case (word_idx)
        PSC_IDX:
          rdata_q <= {24'h00_0000, psc_q};
        DLY_IDX:
          rdata_q <= {8'h00, deep_s_q, 6'h00, lite_ms_q};
        STAT_IDX:
          rdata_q <= {28'h000_0000, motion_detect, state_q};
        default:
          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // ==========================================
  // forced mode codes, decoded from the write data
  // deep code must match all five bits exactly
  assign force_deep = psc_wr
                      && (avs_writedata[4:0] == CODE_DEEP);

  // light and wake ignore the deep enable bit
  assign force_lite = psc_wr && avs_writedata[SLP_BIT]
                      && (avs_writedata[2:0] == CODE_LITE);

  assign force_wake = psc_wr && avs_writedata[SLP_BIT]
                      && (avs_writedata[2:0] == CODE_WAKE);

  // ==========================================
  // enable bits
  // 0xxxx turns sleep off, 10xxx light only, 11xxx both
  assign sleep_en = psc_q[SLP_BIT];
  assign deep_en  = psc_q[SLP_BIT] && psc_q[DEEP_BIT];

  assign led_gating_enable = psc_q[LED_BIT];

  // ==========================================
  // self-clearing request bits
  assign req_pend = |(psc_q[2:0] & REQ_MASK);
  assign req_done = (clr_cnt_q == 4'(REQ_CLR_CYC - 1));

  // delay counter runs only while a request bit stands
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      clr_cnt_q <= 4'h0;
    else if (psc_wr || !req_pend)
      clr_cnt_q <= 4'h0;            // a fresh write restarts the delay
    else if (!req_done)
      clr_cnt_q <= clr_cnt_q + 4'h1;
  end

  // ==========================================
  // power_state_control register
  // a write in the clearing cycle wins over the clear
  // bits 6:5 store whatever software writes; it is
  // expected to write 01 there and nothing checks it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      psc_q <= PSC_RST;
    else if (psc_wr)
      psc_q <= avs_writedata[7:0];
    else if (req_pend && req_done)
      psc_q[2:0] <= 3'h0;
  end

  // ==========================================
  // idle entry delay register
  // byte lanes 0-1 hold light time, lane 2 deep time
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lite_ms_q <= LITE_MS_RST;
      deep_s_q  <= DEEP_S_RST;
    end
    else if (wr_take && word_idx == DLY_IDX)
    begin
      if (avs_byteenable[0])
        lite_ms_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        lite_ms_q[9:8] <= avs_writedata[9:8];
      if (avs_byteenable[2])
        deep_s_q <= avs_writedata[DEEP_LSB +: 8];
    end
  end

  // ==========================================
  // idle timer hookup
  // restart on motion and on any state change, so
  // each state counts only its own idle time
  assign tif.restart = motion_detect
                       || (state_d != state_q);

  // target follows the state; seconds scale to ms
  always_comb
  begin
    if (state_q == ST_LIGHT)
      tif.target_ms = 18'(deep_s_q * MS_PER_S);
    else
      tif.target_ms = {8'h00, lite_ms_q};
  end

  ssmc_idle_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) i_ssmc_idle_timer (
    .clk  (clk),
    .nrst (nrst),
    .tif  (tif)
  );

  // ==========================================
  // power state machine, next state
  // forced codes take priority over idle timeouts;
  // clearing the enables never wakes or sleeps the
  // device by itself
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_NORMAL:
      begin
        if (force_deep)
          state_d = ST_DEEP;
        else if (force_lite)
          state_d = ST_LIGHT;
        else if (sleep_en && !motion_detect && tif.expired)
          state_d = ST_LIGHT;
      end
      ST_LIGHT:
      begin
        if (motion_detect || force_wake)
          state_d = ST_NORMAL;
        else if (force_deep)
          state_d = ST_DEEP;
        else if (deep_en && tif.expired)
          state_d = ST_DEEP;
      end
      ST_DEEP:
      begin
        if (motion_detect || force_wake)
          state_d = ST_NORMAL;
        else if (force_lite)
          state_d = ST_LIGHT;
      end
    endcase
  end

  // ==========================================
  // state register, comes up in normal
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= ST_NORMAL;
    else
      state_q <= state_d;
  end

  // state output straight from the flip-flops
  assign power_state = state_q;

endmodule : ssmc_ctrl

// ### verification/ssmc_ctrl_props.sv
/* checker for the sleep mode controller ports.
   assumes one clock domain and the one-wait avalon slave. */
`timescale 1ns/10ps
module ssmc_ctrl_props
  import ssmc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        motion_detect,
  input wire logic [2:0]  power_state,
  input wire logic        led_gating_enable
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // bus handshake: at most one wait cycle
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without request");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved without read");
  // ==========================================
  // power states
  state_onehot_a: assert property ($onehot(power_state))
    else $error("power state not one-hot");
  motion_wake_a: assert property (motion_detect && !avs_write |=> power_state == ST_NORMAL)
    else $error("motion did not give normal");
  deep_entry_a: assert property ($rose(power_state[2]) |-> $past(power_state[1]) || $past(avs_write))
    else $error("deep sleep entered from normal");
  light_entry_a: assert property ($rose(power_state[1]) |-> !$past(motion_detect))
    else $error("light sleep entered despite motion");
  normal_stay_a: assert property (power_state == ST_NORMAL && !avs_write |=> !power_state[2])
    else $error("normal went straight to deep");
  reset_vals_a: assert property ($rose(nrst) |-> power_state == ST_NORMAL && led_gating_enable)
    else $error("wrong state after reset");
  // main scenarios reached
  deep_c: cover property ($rose(power_state[2]));
  light_c: cover property ($rose(power_state[1]));
  read_c: cover property (avs_read && !avs_waitrequest);
endmodule : ssmc_ctrl_props

// ### verification/ssmc_host_model.sv
/* mouse controller model: programs the sensor registers over avalon-mm.
   assumes the bench calls xfer from one process at a time. */
`timescale 1ns/10ps
module ssmc_host_model (
  input wire logic        clk,
  output logic [9:0]      avs_address,
  output logic            avs_read,
  output logic            avs_write,
  output logic [31:0]     avs_writedata,
  output logic [3:0]      avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  int n_hung;  // accesses that never saw waitrequest low
  initial
  begin
    avs_address    = 10'h3FF;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'hA5A5_A5A5;
    avs_byteenable = 4'hF;
    n_hung         = 0;
  end
  // one access; held until waitrequest is sampled low, then released
  task automatic xfer(input logic rd, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_writedata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) n_hung++;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released lines do not keep their last value
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : ssmc_host_model

// ### verification/tb_ssmc_ctrl.sv
/* self-checking bench for the sleep mode controller.
   assumes MS_CYCLES of 10 so a millisecond is ten clocks. */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_ssmc_ctrl;
  import ssmc_pkg::*;
  logic        clk, nrst, motion_detect, avs_read, avs_write, avs_waitrequest, led_gating_enable;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [2:0]  power_state;
  int          mismatches, n_compared, n;
  ssmc_ctrl #(.MS_CYCLES(10)) i_ssmc_ctrl (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .motion_detect(motion_detect),
    .power_state(power_state), .led_gating_enable(led_gating_enable));
  ssmc_host_model i_ssmc_host_model (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    i_ssmc_host_model.xfer(1'b0, {idx, 2'b00}, d, r);
    if (i_ssmc_host_model.n_hung != 0)
      finish_test();
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    i_ssmc_host_model.xfer(1'b1, {idx, 2'b00}, 32'h0000_0000, q);
    if (i_ssmc_host_model.n_hung != 0)
      finish_test();
  endtask : rd
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (power_state !== s && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (power_state !== s)
    begin
      mismatches++;
      finish_test();
    end
  endtask : wait_st
  task automatic pulse_motion();
    motion_detect <= 1'b1;
    @(posedge clk);
    motion_detect <= 1'b0;
    @(posedge clk);
  endtask : pulse_motion
  // ==========================================
  // scenarios
  task automatic t_reset_regs();
    rd(PSC_IDX);
    `CHK(q, 32'h0000_00B8)
    `CHK(led_gating_enable, 1'b1)
    rd(DLY_IDX);
    `CHK(q, 32'h003D_0100)
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    `CHK(q, 32'h0000_0000)
    $display("test reset_regs done");
  endtask : t_reset_regs
  task automatic t_auto_sleep();
    wr(DLY_IDX, 32'h0001_0004);  // light 4 ms, deep 1 s
    pulse_motion();
    wait_st(ST_LIGHT, 200);
    `CHK(n inside {[25:55]}, 1'b1)
    wait_st(ST_DEEP, 11000);
    `CHK(n inside {[9980:10030]}, 1'b1)
    pulse_motion();
    `CHK(power_state, ST_NORMAL)
    repeat (5)
    begin
      repeat (28) @(posedge clk);
      `CHK(power_state, ST_NORMAL)
      pulse_motion();
    end
    `CHK(power_state, ST_NORMAL)
    $display("test auto_sleep done");
  endtask : t_auto_sleep
  task automatic t_force();
    wr(PSC_IDX, 32'h0000_00BC);  // bits 6:5 kept at 01, one request only
    @(posedge clk);
    `CHK(power_state, ST_DEEP)
    rd(STAT_IDX);
    `CHK(q, 32'h0000_0004)
    repeat (10) @(posedge clk);
    rd(PSC_IDX);
    `CHK(q[7:0], 8'hB8)
    wr(PSC_IDX, 32'h0000_00B9);
    @(posedge clk);
    `CHK(power_state, ST_NORMAL)
    wr(PSC_IDX, 32'h0000_00BA);
    @(posedge clk);
    `CHK(power_state, ST_LIGHT)
    wait_st(ST_DEEP, 11000);
    `CHK(power_state, ST_DEEP)
    wr(PSC_IDX, 32'h0000_00B9);
    @(posedge clk);
    `CHK(power_state, ST_NORMAL)
    $display("test force done");
  endtask : t_force
  task automatic t_nodeep();
    wr(PSC_IDX, 32'h0000_00B0);
    wait_st(ST_LIGHT, 100);
    repeat (10100) @(posedge clk);
    `CHK(power_state, ST_LIGHT)
    wr(PSC_IDX, 32'h0000_00A0);
    repeat (100) @(posedge clk);
    `CHK(power_state, ST_LIGHT)
    pulse_motion();
    repeat (100) @(posedge clk);
    `CHK(power_state, ST_NORMAL)
    // idle time already passed the light delay; restart it so the
    // re-enable does not drop straight into light sleep
    pulse_motion();
    wr(PSC_IDX, 32'h0000_00B8);
    wr(PSC_IDX, 32'h0000_0020);
    repeat (100) @(posedge clk);
    `CHK(power_state, ST_NORMAL)
    `CHK(led_gating_enable, 1'b0)
    $display("test nodeep done");
  endtask : t_nodeep
  // ==========================================
  // verdict, the single place the run ends
  task automatic finish_test();
    mismatches += i_ssmc_host_model.n_hung;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    nrst          = 1'b0;
    motion_detect = 1'b0;
    mismatches    = 0;
    n_compared    = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset_regs();
    t_auto_sleep();
    t_force();
    t_nodeep();
    finish_test();
  end
  // watchdog so no hang runs forever
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule : tb_ssmc_ctrl
bind ssmc_ctrl ssmc_ctrl_props i_ssmc_ctrl_props (.clk(clk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .motion_detect(motion_detect), .power_state(power_state),
  .led_gating_enable(led_gating_enable));
